// ===== bench/core_debug_entry_control_tb_top.sv
// Self-checking bench for the debug entry and clock selection block.
// Assumes the design and the probe model are compiled before it.
module core_debug_entry_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, tck, brk, req, rst, en, mon, sv; // Stimulus nets.
  logic [5:0]  hits;    // Break, watch, fetch, data, end, memory abort.
  logic [31:0] seed;    // Random source state.
  logic [31:0] scan;    // Scanned instruction.
  logic        mq, sq;  // Core memory interface inputs.
  logic        ws;      // Wait stretch level from the far side.
  logic ack, dck, eck, pab, dab, mrq, seq, irq, pv; // Design outputs.
  logic [1:0]  st;      // Abort cause.
  logic [31:0] pi;      // Pipeline instruction.
  int err_count, checks, dr, er; // Counters and clock edge counts.
  logic was_run;        // Previous sample had no acknowledge.
  logic pm, ps;         // Model copy of last driven memory inputs.
  logic [1:0]  cause[3]; // Expected cause per monitor case.
  logic [5:0]  stim[3];  // Stimulus per monitor case.

  core_debug_entry_control u_dut (.clk(clk), .resetn(resetn), .tck(tck),
    .external_break_flag(brk), .debug_request_in(req),
    .debug_feature_enable(en), .monitor_mode_en(mon),
    .restart_request(rst), .cmp_break_hit(hits[5]),
    .cmp_watch_hit(hits[4]), .fetch_execute(hits[3]),
    .data_access(hits[2]), .instr_end(hits[1]), .memory_abort(hits[0]),
    .core_mreq_n(mq), .core_seq(sq), .scan_valid(sv), .scan_instr(scan),
    .debug_acknowledge_out(ack), .debug_core_clock(dck),
    .core_clock_out(eck), .prefetch_abort(pab), .data_abort(dab),
    .abort_status(st), .memory_request_n(mrq), .sequential_cycle(seq),
    .irq_enable(irq), .pipe_instr_valid(pv), .pipe_instr(pi));
  jtag_probe_model u_probe (.clk(clk), .tck(tck),
    .external_break_flag(brk), .debug_request_in(req),
    .restart_request(rst), .wait_stretch_n(ws));

  // Memory clock of 40 ns.
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Counts debug and core clock rises seen in halt.
  always @(posedge dck) dr++;
  always @(posedge eck) er++;

  ////////////////////////////////////////////////////////////////////
  // Random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Compares one value and counts it.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // One cycle: model check of the memory interface, then new inputs.
  task automatic step();
    @(posedge clk);
    #1;
    if (ack === 1'h1)
      cmp(32'({mrq, seq, irq, ws}), 32'h9);
    else if (was_run)
      cmp(32'({mrq, seq, dck, irq}), 32'({pm, ps, 2'h1}));
    was_run = (ack === 1'h0);
    seed = lfsr(seed);
    pm = seed[0];
    ps = seed[1];
    mq = pm;
    sq = ps;
  endtask : step
  // Picks a watched output.
  function automatic logic sel(input int k);
    case (k)
      0: sel = ack;
      1: sel = pab;
      default: sel = dab;
    endcase
  endfunction : sel
  // Bounded wait for a watched output to reach a level.
  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while (sel(k) !== v && n < 12)
    begin
      step();
      n++;
    end
    cmp(32'(sel(k)), 32'(v));
    if (n == 12)
      end_sim();
  endtask : wait_on
  // Restart from halt and see the acknowledge drop.
  task automatic leave();
    u_probe.drive(1'h0, 1'h0, 1'h1);
    wait_on(0, 1'h0);
    u_probe.drive(1'h0, 1'h0, 1'h0);
    repeat (3) step();
  endtask : leave

  ////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {resetn, en, mon, sv, mq, sq, was_run, pm, ps} = 9'h090;
    hits = 6'h00;
    seed = 32'h4d24;
    scan = 32'h0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'h1;
    repeat (3) step();
    // Comparator breakpoint in halt mode, clocks, scan, restart.
    hits = 6'h28;
    step();
    hits = 6'h00;
    wait_on(0, 1'h1);
    scan = lfsr(seed ^ 32'h5a5a);
    sv = 1'h1;
    // Let the hand-over finish: the memory clock may rise once before it.
    repeat (2) step();
    {dr, er} = {32'h0, 32'h0};
    fork
      u_probe.frame(3);
      repeat (20) step();
    join
    cmp(32'(dr), 32'h3);
    cmp(32'(er), 32'(dr));
    cmp(pi, scan);
    sv = 1'h0;
    leave();
    $display("test halt breakpoint done");
    // External flag watchpoint, taken only at instruction end.
    hits = 6'h04;
    u_probe.drive(1'h1, 1'h0, 1'h0);
    repeat (5) step();
    cmp(32'(ack), 32'h0);
    hits = 6'h06;
    step();
    hits = 6'h00;
    u_probe.drive(1'h0, 1'h0, 1'h0);
    wait_on(0, 1'h1);
    leave();
    $display("test watchpoint done");
    // Asynchronous debug request, taken at instruction end.
    u_probe.drive(1'h0, 1'h1, 1'h0);
    repeat (5) step();
    cmp(32'(ack), 32'h0);
    hits = 6'h02;
    step();
    hits = 6'h00;
    u_probe.drive(1'h0, 1'h0, 1'h0);
    wait_on(0, 1'h1);
    leave();
    $display("test debug request done");
    // Monitor mode: aborts and causes; breakpoint beats watchpoint.
    mon = 1'h1;
    repeat (3) step();
    stim = '{6'h28, 6'h14, 6'h3c};
    cause = '{2'h1, 2'h2, 2'h1};
    for (int i = 0; i < 3; i++)
    begin
      hits = stim[i];
      step();
      hits = 6'h00;
      wait_on((i == 1) ? 2 : 1, 1'h1);
      step();
      cmp(32'(st), 32'(cause[i]));
    end
    hits = 6'h01;
    step();
    hits = 6'h00;
    repeat (3) step();
    cmp(32'(st), 32'h3);
    u_probe.drive(1'h0, 1'h1, 1'h0);
    hits = 6'h02;
    repeat (6) step();
    cmp(32'({ack, dck}), 32'h0);
    u_probe.drive(1'h0, 1'h0, 1'h0);
    {mon, hits} = 7'h00;
    repeat (3) step();
    $display("test monitor mode done");
    // Debug features disabled: a breakpoint is refused.
    en = 1'h0;
    repeat (3) step();
    hits = 6'h28;
    step();
    hits = 6'h00;
    repeat (6) step();
    cmp(32'(ack), 32'h0);
    $display("test disabled done");
    end_sim();
  end
endmodule : core_debug_entry_control_tb_top

// ===== bench/jtag_probe_model.sv
// Far-side model: debug probe and external break logic.
// Assumes the bench calls its tasks just after a rising clk edge.
module jtag_probe_model (
  input  wire logic clk,
  output logic      tck,
  output logic      external_break_flag,
  output logic      debug_request_in,
  output logic      restart_request,
  output logic      wait_stretch_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // The test clock stands still low and no request is raised at start.
  initial
  begin
    tck = 1'h0;
    external_break_flag = 1'h0;
    debug_request_in = 1'h0;
    restart_request = 1'h0;
    // The system keeps the wait stretch high throughout, debug included.
    wait_stretch_n = 1'h1;
  end

  // Sets break flag, debug request and restart levels at once.
  task automatic drive(input logic f, input logic r, input logic s);
    external_break_flag = f;
    debug_request_in = r;
    restart_request = s;
  endtask : drive

  // Runs n slow test clock periods inside a frame, then rests low.
  task automatic frame(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk);
      #1 tck = 1'h1;
      repeat (3) @(posedge clk);
      #1 tck = 1'h0;
    end
  endtask : frame
endmodule : jtag_probe_model

// ===== rtl/core_debug_entry_control.sv
// Debug entry, abort signalling and core clock selection for a core.
// Assumes clk is the memory clock source; pins tck, break, request,
// enable, mode and restart come from outside and are synchronised here.
// Behaviour
// - Halt mode breaks stop core in debug.
// - Monitor mode breaks raise aborts, interrupts continue.
// - Breakpoint, watchpoint or request activates debug.
// - Halt mode shifts scanned instructions into pipeline.
// - Monitor mode JTAG only carries monitor data.
// - Two clocks: memory clock, debug from TCK.
// - Normally memory clock runs, debug clock low.
// - Halt mode core follows debug clock.
// - Selected clock drives core clock output.
// - Monitor mode keeps memory clock, no debug.
// - Break and request enter debug; acknowledge asserted.
// - Monitor mode records abort cause in status.
// - Comparators or external flag mark breaks.
// - Flag during load/store marks watchpoint.
// - Debug request synchronised, taken at instruction end.
// - Debug state shows internal memory cycles.
// - Clock switch on next memory clock fall; the switch back to the memory clock on restart does not wait for a fall.
`include "dbg_entry_defs.svh"
module core_debug_entry_control (
  input  wire logic        clk,                   // Memory clock source.
  input  wire logic        resetn,                // Async reset, low.
  input  wire logic        tck,                   // JTAG test clock pin.
  input  wire logic        external_break_flag,   // Break pin.
  input  wire logic        debug_request_in,      // Async request pin.
  input  wire logic        debug_feature_enable,  // Debug enable pin.
  input  wire logic        monitor_mode_en,       // High for monitor mode.
  input  wire logic        restart_request,       // TAP restart level.
  input  wire logic        cmp_break_hit,         // Comparator breakpoint.
  input  wire logic        cmp_watch_hit,         // Comparator watchpoint.
  input  wire logic        fetch_execute,         // Fetched instr executes.
  input  wire logic        data_access,           // Load or store data.
  input  wire logic        instr_end,             // Instruction completes.
  input  wire logic        memory_abort,          // Genuine memory abort.
  input  wire logic        core_mreq_n,           // Core memory request.
  input  wire logic        core_seq,              // Core sequential flag.
  input  wire logic        scan_valid,            // Scanned instr ready.
  input  wire logic [31:0] scan_instr,            // Scanned instruction.
  output logic             debug_acknowledge_out, // Core in debug state.
  output logic             debug_core_clock,      // Debug clock.
  output logic             core_clock_out,        // Selected core clock.
  output logic             prefetch_abort,        // Instruction abort.
  output logic             data_abort,            // Data abort.
  output logic [1:0]       abort_status,          // Abort cause.
  output logic             memory_request_n,      // Memory request.
  output logic             sequential_cycle,      // Sequential cycle.
  output logic             irq_enable,            // Interrupts serviced.
  output logic             pipe_instr_valid,      // Instr pushed to pipe.
  output logic [31:0]      pipe_instr             // Instr for pipeline.
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  ////////////////////////////////////////////////////////////////////////

  logic [5:0] sync1_ff, nxt_sync1;        // First stage, feeds second only.
  logic [5:0] sync2_ff, nxt_sync2;        // Second stage, safe to use.
  logic       tck_prev_ff, nxt_tck_prev;  // Delayed test clock for edges.

  // Gather all pins into the first stage, then pass to the second.
  always_comb
  begin
    nxt_sync1 = {tck, external_break_flag, debug_request_in,
                 debug_feature_enable, monitor_mode_en, restart_request};
    nxt_sync2 = sync1_ff;
    nxt_tck_prev = sync2_ff[5];
  end

  // Register the synchroniser stages.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_ff    <= 6'h00;
      sync2_ff    <= 6'h00;
      tck_prev_ff <= 1'h0;
    end
    else
    begin
      sync1_ff    <= nxt_sync1;
      sync2_ff    <= nxt_sync2;
      tck_prev_ff <= nxt_tck_prev;
    end
  end

  // Synchronised test clock, break, request, enable, monitor, restart.
  logic tck_s, brk_s, req_s, en_s, mon_s, rst_s;
  logic tck_rise;  // Test clock rising edge.
  assign {tck_s, brk_s, req_s, en_s, mon_s, rst_s} = sync2_ff;
  assign tck_rise = tck_s & ~tck_prev_ff;

  ////////////////////////////////////////////////////////////////////////
  // Break detection.
  ////////////////////////////////////////////////////////////////////////

  logic brk_hit, wpt_hit;  // Breakpoint on fetch, watchpoint on data.
  // Comparators or the external flag mark either kind.
  assign brk_hit = en_s & fetch_execute & (cmp_break_hit | brk_s);
  assign wpt_hit = en_s & data_access & (cmp_watch_hit | brk_s);

  ////////////////////////////////////////////////////////////////////////
  // Debug state machine and outputs.
  ////////////////////////////////////////////////////////////////////////

  dbg_entry_pkg::dbg_state_t   state_ff, nxt_state;    // Debug state.
  logic                        mphase_ff, nxt_mphase;  // Memory clock phase.
  logic                        ack_ff, nxt_ack;        // Acknowledge.
  logic                        debug_core_clock_ff, nxt_debug_core_clock;      // Debug clock.
  logic                        cclk_ff, nxt_cclk;      // Core clock.
  logic                        pabt_ff, nxt_pabt;      // Instruction abort.
  logic                        dabt_ff, nxt_dabt;      // Data abort.
  dbg_entry_pkg::abort_cause_t abt_ff, nxt_abt;        // Abort cause.
  logic                        mreq_n_ff, nxt_mreq_n;  // Memory request.
  logic                        seq_ff, nxt_seq;        // Sequential out.
  logic                        irq_ff, nxt_irq;        // Interrupt enable.
  logic                        piv_ff, nxt_piv;        // Pipe instr valid.
  logic [31:0]                 pi_ff, nxt_pi;          // Pipe instruction.
  logic                        mfall;                  // Memory clock falls.
  logic                        in_dbg;                 // Core in debug.

  assign mfall  = mphase_ff;
  assign in_dbg = (state_ff == dbg_entry_pkg::ST_SWITCH) ||
                  (state_ff == dbg_entry_pkg::ST_HALT);

  // Compute next state, clocks, aborts and memory interface flags.
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_mphase = ~mphase_ff;
    nxt_pabt   = 1'h0;
    nxt_dabt   = 1'h0;
    nxt_abt    = abt_ff;
    nxt_piv    = 1'h0;
    nxt_pi     = pi_ff;
    unique case (state_ff)
      dbg_entry_pkg::ST_RUN:
      begin
        if (mon_s)
        begin
          // Monitor mode aborts and records why; no debug state.
          nxt_pabt = brk_hit;
          nxt_dabt = wpt_hit;
          if (brk_hit)
            nxt_abt = `ABT_BREAK;
          else if (wpt_hit)
            nxt_abt = `ABT_WATCH;
          else if (memory_abort)
            nxt_abt = `ABT_MEMORY;
        end
        else if (brk_hit)
          // A breakpointed instruction is not executed.
          nxt_state = dbg_entry_pkg::ST_SWITCH;
        else if (wpt_hit || (en_s && req_s))
          // Watchpoints and requests wait for the instruction to end.
          nxt_state = instr_end ? dbg_entry_pkg::ST_SWITCH
                                : dbg_entry_pkg::ST_PEND;
      end
      dbg_entry_pkg::ST_PEND:
      begin
        if (instr_end)
          nxt_state = dbg_entry_pkg::ST_SWITCH;
      end
      dbg_entry_pkg::ST_SWITCH:
      begin
        // Hand the core over at the next memory clock fall.
        if (mfall)
          nxt_state = dbg_entry_pkg::ST_HALT;
      end
      dbg_entry_pkg::ST_HALT:
      begin
        // Scanned instructions enter on the debug clock rise.
        if (tck_rise && scan_valid)
        begin
          nxt_piv = 1'h1;
          nxt_pi  = scan_instr;
        end
        if (rst_s)
          nxt_state = dbg_entry_pkg::ST_RUN;
      end
    endcase
    nxt_ack  = (nxt_state == dbg_entry_pkg::ST_SWITCH) ||
               (nxt_state == dbg_entry_pkg::ST_HALT);
    // Debug clock held low unless halted.
    nxt_debug_core_clock = (nxt_state == dbg_entry_pkg::ST_HALT) ? tck_s
                                                     : 1'h0;
    nxt_cclk = (nxt_state == dbg_entry_pkg::ST_HALT) ? tck_s
                                                     : nxt_mphase;
    // Debug state hides the core from memory with internal cycles.
    nxt_mreq_n = nxt_ack ? 1'h1 : core_mreq_n;
    nxt_seq    = nxt_ack ? 1'h0 : core_seq;
    nxt_irq    = ~nxt_ack;
  end

  // Register state and outputs.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff  <= dbg_entry_pkg::ST_RUN;
      mphase_ff <= 1'h0;
      ack_ff    <= 1'h0;
      debug_core_clock_ff   <= `CLK_RESET;
      cclk_ff   <= `CLK_RESET;
      pabt_ff   <= 1'h0;
      dabt_ff   <= 1'h0;
      abt_ff    <= `ABT_NONE;
      mreq_n_ff <= 1'h1;
      seq_ff    <= 1'h0;
      irq_ff    <= 1'h1;
      piv_ff    <= 1'h0;
      pi_ff     <= 32'h00000000;
    end
    else
    begin
      state_ff  <= nxt_state;
      mphase_ff <= nxt_mphase;
      ack_ff    <= nxt_ack;
      debug_core_clock_ff   <= nxt_debug_core_clock;
      cclk_ff   <= nxt_cclk;
      pabt_ff   <= nxt_pabt;
      dabt_ff   <= nxt_dabt;
      abt_ff    <= nxt_abt;
      mreq_n_ff <= nxt_mreq_n;
      seq_ff    <= nxt_seq;
      irq_ff    <= nxt_irq;
      piv_ff    <= nxt_piv;
      pi_ff     <= nxt_pi;
    end
  end

  assign debug_acknowledge_out = ack_ff;
  assign debug_core_clock      = debug_core_clock_ff;
  assign core_clock_out        = cclk_ff;
  assign prefetch_abort        = pabt_ff;
  assign data_abort            = dabt_ff;
  assign abort_status          = abt_ff;
  assign memory_request_n      = mreq_n_ff;
  assign sequential_cycle      = seq_ff;
  assign irq_enable            = irq_ff;
  assign pipe_instr_valid      = piv_ff;
  assign pipe_instr            = pi_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_halt_break_enter: assert property (
    (state_ff == dbg_entry_pkg::ST_RUN) && !mon_s && brk_hit
    |=> (state_ff == dbg_entry_pkg::ST_SWITCH) ##[1:2] ack_ff && in_dbg)
    else $error("halt breakpoint did not enter debug");
  chk_monitor_abort: assert property (
    (state_ff == dbg_entry_pkg::ST_RUN) && mon_s && brk_hit
    |=> prefetch_abort && !ack_ff && (abort_status == `ABT_BREAK))
    else $error("monitor breakpoint did not abort");
  chk_monitor_watch: assert property (
    (state_ff == dbg_entry_pkg::ST_RUN) && mon_s && !brk_hit && wpt_hit
    |=> data_abort && (abort_status == `ABT_WATCH))
    else $error("monitor watchpoint cause wrong");
  chk_request_waits: assert property (
    (state_ff == dbg_entry_pkg::ST_PEND) && !instr_end
    |=> (state_ff == dbg_entry_pkg::ST_PEND))
    else $error("request left pending before instruction end");
  chk_debug_core_clock_low: assert property (
    (state_ff != dbg_entry_pkg::ST_HALT) |-> !debug_core_clock)
    else $error("debug clock not held low");
  chk_switch_fall: assert property (
    (state_ff == dbg_entry_pkg::ST_SWITCH) && mfall
    |=> (state_ff == dbg_entry_pkg::ST_HALT))
    else $error("clock switch missed memory clock fall");
  chk_halt_clock: assert property (
    (state_ff == dbg_entry_pkg::ST_HALT) && !rst_s
    |=> core_clock_out == $past(tck_s) && debug_core_clock == core_clock_out)
    else $error("halt core clock not debug clock");
  chk_internal_cycles: assert property (
    ack_ff |-> memory_request_n && !sequential_cycle && !irq_enable)
    else $error("debug state not internal cycles");
  chk_ack_release: assert property (
    (state_ff == dbg_entry_pkg::ST_HALT) && rst_s |=> !ack_ff [*2])
    else $error("acknowledge held after restart");
  chk_scan_push: assert property (
    (state_ff == dbg_entry_pkg::ST_HALT) && tck_rise && scan_valid
    |=> pipe_instr_valid && (pipe_instr == $past(scan_instr)))
    else $error("scanned instruction not pushed");
  cov_halt_entry: cover property (
    (state_ff == dbg_entry_pkg::ST_RUN) ##1 in_dbg ##[1:4] rst_s);
  cov_monitor_abort: cover property (mon_s && brk_hit ##1 prefetch_abort);
  cov_request_pend: cover property (
    (state_ff == dbg_entry_pkg::ST_PEND) ##[1:8]
    (state_ff == dbg_entry_pkg::ST_HALT));
endmodule : core_debug_entry_control

// ===== rtl/dbg_entry_defs.svh
// Constants for the debug entry and clock selection logic.
// Assumes inclusion by bare name from files in rtl/.
`ifndef DBG_ENTRY_DEFS_SVH
`define DBG_ENTRY_DEFS_SVH
// Abort cause codes held in the abort status output.
`define ABT_NONE    2'h0
`define ABT_BREAK   2'h1
`define ABT_WATCH   2'h2
`define ABT_MEMORY  2'h3
// Reset value of the core clock output and the debug clock.
`define CLK_RESET   1'h0
`endif

// ===== rtl/dbg_entry_pkg.sv
// Types for the debug entry and clock selection logic.
// Assumes nothing beyond a SystemVerilog compiler.
package dbg_entry_pkg;
  // Debug state machine: run, wait for instruction end, wait for the
  // memory clock fall, halted on the debug clock.
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_PEND   = 2'b01,
    ST_SWITCH = 2'b10,
    ST_HALT   = 2'b11
  } dbg_state_t;
  // Abort cause field.
  typedef logic [1:0] abort_cause_t;
endpackage : dbg_entry_pkg
